// ---- smb_idreg_pkg.sv ----
/*
 * Constants, states and carriers shared by the identification and
 * byte-count register block of the clock buffer's serial management port.
 * Assumes the bit-level pins arrive already synchronous to the core clock.
 */
`default_nettype none

package smb_idreg_pkg;

    // ************************************************************
    // register indexes
    // ************************************************************
    localparam logic [7:0] IDX_RSVD_A = 8'h03;
    localparam logic [7:0] IDX_RSVD_B = 8'h04;
    localparam logic [7:0] IDX_VEND_REV = 8'h05;
    localparam logic [7:0] IDX_PART = 8'h06;
    localparam logic [7:0] IDX_COUNT = 8'h07;
    localparam logic [7:0] IDX_RSVD_C = 8'h08;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int COUNT_W = 5;
    localparam logic [4:0] COUNT_RESET = 5'h08;
    localparam logic [2:0] COUNT_RSVD = 3'h0;
    localparam logic [7:0] RSVD_BYTE = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [7:0] BYTE_STEP = 8'h01;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_WCNT = 4'h7,
        ST_WCNT_ACK = 4'h5,
        ST_WDATA = 4'h4,
        ST_WDATA_ACK = 4'hC,
        ST_TX = 4'hD,
        ST_TX_ACK = 4'hF
    } smb_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } smb_pins_t;

endpackage

`default_nettype wire

// ---- smb_idreg.sv ----
/*
 * Serial management slave holding register bytes 3 to 8: two reserved
 * bytes, the revision/maker identity, the part identity, the read-length
 * count and a last reserved byte, with indexed block write and block read.
 * Assumes scl and sda are already synchronous to i_mclk; the open-drain
 * wire level is resolved outside from o_sda_oe.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R01] host writes the count field; later block reads use it as their length
// [R02] count resets to 8 hex, so a block read returns nine bytes
// [R03] count lives at index 7; low five bits count, top three read zero
// [R04] index 5 is read-only: revision in upper nibble, maker code in lower
// [R05] block read from index N with count X sends N..N+X-1 ascending
// [R06] host acks every read byte but the last, then nacks and stops
// [R07] indexes 3, 4, 6 and 8 ignore writes; reserved bits read zero
module smb_idreg #(
    parameter logic [6:0] SLAVE_ADDR = 7'h6C,
    parameter logic [3:0] SILICON_REV = 4'h3,   // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'hA,    // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5A     // arbitrary value
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [smb_idreg_pkg::COUNT_W-1:0] o_read_length
);

    // ************************************************************
    // state
    // ************************************************************
    smb_idreg_pkg::smb_pins_t cur_pins;
    smb_idreg_pkg::smb_pins_t pins_reg;
    smb_idreg_pkg::smb_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] remain_reg, remain_next;
    logic [4:0] count_reg, count_next;
    logic first_reg, first_next;
    logic rd_reg, rd_next;
    logic oe_reg, oe_next;
    logic ack_reg, ack_next;
    logic fresh_reg;
    logic wr_en;
    logic load_tx;
    logic [7:0] tx_byte;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic [4:0] cnt);
        case (idx)
            smb_idreg_pkg::IDX_VEND_REV: read_byte = {SILICON_REV, MAKER_CODE}; // [R04]
            smb_idreg_pkg::IDX_PART: read_byte = PART_CODE;
            smb_idreg_pkg::IDX_COUNT: read_byte = {smb_idreg_pkg::COUNT_RSVD, cnt}; // [R03]
            default: read_byte = smb_idreg_pkg::RSVD_BYTE; // [R07]
        endcase
    endfunction

    assign cur_pins = '{scl: i_scl, sda: i_sda};
    assign scl_rise = cur_pins.scl & ~pins_reg.scl;
    assign scl_fall = ~cur_pins.scl & pins_reg.scl;
    assign start_cond = cur_pins.scl & pins_reg.scl & pins_reg.sda & ~cur_pins.sda;
    assign stop_cond = cur_pins.scl & pins_reg.scl & ~pins_reg.sda & cur_pins.sda;

    // ************************************************************
    // protocol engine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        remain_next = remain_reg;
        count_next = count_reg;
        first_next = first_reg;
        rd_next = rd_reg;
        oe_next = oe_reg;
        ack_next = ack_reg;
        wr_en = 1'b0;
        load_tx = 1'b0;
        tx_byte = smb_idreg_pkg::IDLE_BYTE;
        // start or stop may come at any time; a repeated start re-enters addressing
        if (start_cond) begin
            state_next = smb_idreg_pkg::ST_ADDR;
            bit_next = smb_idreg_pkg::BIT_ZERO;
            oe_next = 1'b0;
        end else if (stop_cond) begin
            state_next = smb_idreg_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                smb_idreg_pkg::ST_ADDR, smb_idreg_pkg::ST_CMD,
                smb_idreg_pkg::ST_WCNT, smb_idreg_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], cur_pins.sda};
                        bit_next = bit_reg + smb_idreg_pkg::BIT_STEP;
                    end else if (scl_fall && bit_reg == smb_idreg_pkg::BITS_PER_BYTE) begin
                        bit_next = smb_idreg_pkg::BIT_ZERO;
                        oe_next = 1'b1;
                        case (state_reg)
                            smb_idreg_pkg::ST_ADDR: begin
                                // foreign address: stay silent until the next start
                                if (shift_reg[7:1] == SLAVE_ADDR) begin
                                    rd_next = shift_reg[0];
                                    state_next = smb_idreg_pkg::ST_ADDR_ACK;
                                end else begin
                                    oe_next = 1'b0;
                                    state_next = smb_idreg_pkg::ST_IDLE;
                                end
                            end
                            smb_idreg_pkg::ST_CMD: begin
                                ptr_next = shift_reg;
                                state_next = smb_idreg_pkg::ST_CMD_ACK;
                            end
                            smb_idreg_pkg::ST_WCNT: begin
                                remain_next = shift_reg;
                                state_next = smb_idreg_pkg::ST_WCNT_ACK;
                            end
                            default: begin
                                // bytes past the announced count are acked but dropped
                                if (remain_reg != smb_idreg_pkg::RSVD_BYTE) begin
                                    wr_en = 1'b1;
                                    ptr_next = ptr_reg + smb_idreg_pkg::BYTE_STEP;
                                    remain_next = remain_reg - smb_idreg_pkg::BYTE_STEP;
                                end
                                state_next = smb_idreg_pkg::ST_WDATA_ACK;
                            end
                        endcase
                    end
                end
                smb_idreg_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        if (rd_reg) begin
                            remain_next = {smb_idreg_pkg::COUNT_RSVD, count_reg}; // [R01]
                            load_tx = 1'b1;
                        end else begin
                            state_next = smb_idreg_pkg::ST_CMD;
                        end
                    end
                end
                smb_idreg_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = smb_idreg_pkg::ST_WCNT;
                    end
                end
                smb_idreg_pkg::ST_WCNT_ACK, smb_idreg_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = smb_idreg_pkg::ST_WDATA;
                    end
                end
                smb_idreg_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == smb_idreg_pkg::LAST_BIT) begin
                            bit_next = smb_idreg_pkg::BIT_ZERO;
                            oe_next = 1'b0;
                            state_next = smb_idreg_pkg::ST_TX_ACK;
                        end else begin
                            bit_next = bit_reg + smb_idreg_pkg::BIT_STEP;
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                        end
                    end
                end
                smb_idreg_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_next = ~cur_pins.sda;
                    end else if (scl_fall) begin
                        // a nack ends the read; the host then stops
                        if (ack_reg) begin // [R06]
                            load_tx = 1'b1;
                        end else begin
                            state_next = smb_idreg_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // count byte first, then the data run; idle ones once the run is spent
        // first_reg marks the count byte while it is on the wire
        if (load_tx) begin
            first_next = (state_reg == smb_idreg_pkg::ST_ADDR_ACK);
            if (first_next) begin
                tx_byte = {smb_idreg_pkg::COUNT_RSVD, count_reg};
            end else if (remain_reg != smb_idreg_pkg::RSVD_BYTE) begin
                tx_byte = read_byte(ptr_reg, count_reg);
                ptr_next = ptr_reg + smb_idreg_pkg::BYTE_STEP; // [R05]
                remain_next = remain_reg - smb_idreg_pkg::BYTE_STEP;
            end
            shift_next = tx_byte;
            oe_next = ~tx_byte[7];
            bit_next = smb_idreg_pkg::BIT_ZERO;
            state_next = smb_idreg_pkg::ST_TX;
        end
        // only the count field takes writes; the others are fixed or reserved
        if (wr_en && ptr_reg == smb_idreg_pkg::IDX_COUNT) begin // [R07]
            count_next = shift_reg[smb_idreg_pkg::COUNT_W-1:0]; // [R01] [R03]
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_reg <= '{scl: 1'b1, sda: 1'b1};
            state_reg <= smb_idreg_pkg::ST_IDLE;
            bit_reg <= smb_idreg_pkg::BIT_ZERO;
            shift_reg <= smb_idreg_pkg::RSVD_BYTE;
            ptr_reg <= smb_idreg_pkg::RSVD_BYTE;
            remain_reg <= smb_idreg_pkg::RSVD_BYTE;
            count_reg <= smb_idreg_pkg::COUNT_RESET; // [R02]
            first_reg <= 1'b0;
            rd_reg <= 1'b0;
            oe_reg <= 1'b0;
            ack_reg <= 1'b0;
            fresh_reg <= 1'b1;
        end else begin
            pins_reg <= cur_pins;
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            remain_reg <= remain_next;
            count_reg <= count_next;
            first_reg <= first_next;
            rd_reg <= rd_next;
            oe_reg <= oe_next;
            ack_reg <= ack_next;
            fresh_reg <= 1'b0;
        end
    end

    // open drain: only ever pulls low
    assign o_sda_out = 1'b0 & oe_reg;
    assign o_sda_oe = oe_reg;
    assign o_read_length = count_reg;

    // ************************************************************
    // checks
    // ************************************************************
    a_count_write_only: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R01]
        (count_reg != $past(count_reg)) |-> $past(wr_en && ptr_reg == smb_idreg_pkg::IDX_COUNT))
        else $error("count changed without a write to its index");
    a_count_reset_value: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R02]
        fresh_reg |-> count_reg == smb_idreg_pkg::COUNT_RESET)
        else $error("count not at default after reset");
    a_count_rsvd_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R03]
        (load_tx && !first_next && ptr_reg == smb_idreg_pkg::IDX_COUNT
            && remain_reg != smb_idreg_pkg::RSVD_BYTE)
        |=> shift_reg[7:5] == smb_idreg_pkg::COUNT_RSVD && shift_reg[4:0] == $past(count_reg))
        else $error("count byte sent wrongly");
    a_ident_fixed: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R04]
        (load_tx && !first_next && ptr_reg == smb_idreg_pkg::IDX_VEND_REV
            && remain_reg != smb_idreg_pkg::RSVD_BYTE)
        |=> shift_reg == {SILICON_REV, MAKER_CODE})
        else $error("identity byte wrong");
    a_read_ascend: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R05]
        (state_reg == smb_idreg_pkg::ST_TX_ACK && scl_fall && ack_reg && !first_reg
            && remain_reg != smb_idreg_pkg::RSVD_BYTE && !start_cond && !stop_cond)
        |=> ptr_reg == $past(ptr_reg) + smb_idreg_pkg::BYTE_STEP
            && state_reg == smb_idreg_pkg::ST_TX)
        else $error("read index did not step by one");
    a_ignored_writes: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // [R07]
        (wr_en && ptr_reg != smb_idreg_pkg::IDX_COUNT) |=> $stable(count_reg))
        else $error("write to a fixed byte changed state");
    c_block_read: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
        state_reg == smb_idreg_pkg::ST_TX_ACK && scl_fall && !ack_reg);
    c_count_write: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
        wr_en && ptr_reg == smb_idreg_pkg::IDX_COUNT);
    c_ignored_write: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
        wr_en && ptr_reg == smb_idreg_pkg::IDX_PART);

endmodule // smb_idreg

`default_nettype wire

// ---- smb_host_model.sv ----
/*
 * Host controller model for the serial management port: start, repeated
 * start, stop, byte write and byte read, called as tasks by the bench.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none
module smb_host_model (
    input wire logic i_mclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // ********************************************************
    // bus phases, 4 mclk per scl half, above the slave's 3
    // ********************************************************
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // also a repeated start when scl is low
    task automatic start_cond();
        o_sda_oe = 1'b0;
        wt(2);
        o_scl = 1'b1;
        wt(3);
        o_sda_oe = 1'b1;
        wt(3);
        o_scl = 1'b0;
        wt(2);
    endtask
    task automatic stop_cond();
        o_sda_oe = 1'b1;
        wt(2);
        o_scl = 1'b1;
        wt(3);
        o_sda_oe = 1'b0;
        wt(4);
    endtask
    // sda changes only while scl low; sampled mid-high
    task automatic bit_cell(input logic b, output logic r);
        o_sda_oe = ~b;
        wt(2);
        o_scl = 1'b1;
        wt(2);
        r = i_sda;
        wt(2);
        o_scl = 1'b0;
        wt(2);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cell(d[i], r);
        bit_cell(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cell(1'b1, r);
            d[i] = r;
        end
        bit_cell(last, r);
    endtask
endmodule // smb_host_model
`default_nettype wire

// ---- smbus_id_and_byte_count_regs_tb_top.sv ----
/*
 * Self-checking bench for the identity and read-length register block.
 * Assumes smb_idreg and smb_host_model are compiled beforehand.
 */
`timescale 1ns/10ps
`default_nettype none
module smbus_id_and_byte_count_regs_tb_top;
    localparam logic [6:0] ADDR = 7'h6C;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [3:0] MAKER = 4'hA; // arbitrary value
    localparam logic [7:0] PART = 8'h5A; // arbitrary value
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wdata;
        logic [4:0] cnt;
    } row_t;
    logic mclk;
    logic arst_n;
    logic scl;
    logic host_oe;
    logic dev_oe;
    logic dev_out;
    logic [4:0] rd_len;
    logic ack;
    wire logic sda;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    row_t rows [7] = '{'{8'h07, 8'hE4, 5'h04}, '{8'h05, 8'h00, 5'h04}, '{8'h06, 8'hFF, 5'h04},
        '{8'h03, 8'hFF, 5'h04}, '{8'h04, 8'hFF, 5'h04}, '{8'h08, 8'hFF, 5'h04},
        '{8'h07, 8'h02, 5'h02}};
    // pull-up wire: low if either side pulls
    assign sda = ~host_oe & (dev_oe ? dev_out : 1'b1);
    smb_idreg #(.SLAVE_ADDR(ADDR), .SILICON_REV(REV), .MAKER_CODE(MAKER), .PART_CODE(PART))
        smb_idreg_i (.i_mclk(mclk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(dev_out), .o_sda_oe(dev_oe), .o_read_length(rd_len));
    smb_host_model smb_host_model_i (.i_mclk(mclk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(host_oe));
    // ********************************************************
    // clock, timeout and reporting
    // ********************************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [7:0] idx, input logic [4:0] cnt);
        case (idx)
            8'h05: return {REV, MAKER};
            8'h06: return PART;
            8'h07: return {3'h0, cnt};
            default: return 8'h00;
        endcase
    endfunction
    // ********************************************************
    // bus transfers
    // ********************************************************
    task automatic send_addr(input logic rnw);
        smb_host_model_i.start_cond();
        smb_host_model_i.wr_byte({ADDR, rnw}, ack);
        chk({7'h00, ack}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] idx, x, d0, d1, input int n);
        logic [7:0] seq [4];
        seq = '{idx, x, d0, d1};
        send_addr(1'b0);
        for (int i = 0; i < n + 2; i++) begin
            smb_host_model_i.wr_byte(seq[i], ack);
            chk({7'h00, ack}, 8'h01);
        end
        smb_host_model_i.stop_cond();
    endtask
    // n data bytes read; those beyond the count expect idle bytes
    task automatic rd(input logic [7:0] idx, input logic [4:0] cnt, input int n);
        logic [7:0] d;
        send_addr(1'b0);
        smb_host_model_i.wr_byte(idx, ack);
        chk({7'h00, ack}, 8'h01);
        send_addr(1'b1);
        smb_host_model_i.rd_byte(n == 0, d);
        chk(d, {3'h0, cnt});
        for (int i = 0; i < n; i++) begin
            smb_host_model_i.rd_byte(i == n - 1, d);
            chk(d, (i < cnt) ? exp_byte(idx + 8'(i), cnt) : 8'hFF);
        end
        smb_host_model_i.stop_cond();
    endtask
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        arst_n = 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        chk({3'h0, rd_len}, 8'h08);
        rd(8'h00, 5'h08, 8);
        foreach (rows[k]) begin
            wr(rows[k].idx, 8'h01, rows[k].wdata, 8'h00, 1);
            chk({3'h0, rd_len}, {3'h0, rows[k].cnt});
            rd(8'h09 - {3'h0, rows[k].cnt}, rows[k].cnt, 32'(rows[k].cnt));
        end
        // two-byte run: index 6 ignored, then index 7 takes the value
        wr(8'h06, 8'h02, 8'h11, 8'h06, 2);
        chk({3'h0, rd_len}, 8'h06);
        rd(8'h03, 5'h06, 7);
        // byte beyond the announced count is dropped
        wr(8'h07, 8'h01, 8'h00, 8'h1F, 2);
        chk({3'h0, rd_len}, 8'h00);
        rd(8'h07, 5'h00, 1);
        smb_host_model_i.start_cond();
        smb_host_model_i.wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
        chk({7'h00, ack}, 8'h00);
        smb_host_model_i.stop_cond();
        wr(8'h07, 8'h01, 8'h1F, 8'h00, 1);
        chk({3'h0, rd_len}, 8'h1F);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        chk({3'h0, rd_len}, 8'h08);
        arst_n = 1'b1;
        rd(8'h05, 5'h08, 4);
        finish_test();
    end
endmodule // smbus_id_and_byte_count_regs_tb_top
`default_nettype wire
